// File: hw/phap_pkg.sv
package phap_pkg;
    // Target-select codes on the two select inputs.
    localparam logic [1:0] SEL_ADDR_A = 2'h0;
    localparam logic [1:0] SEL_PALETTE = 2'h1;
    localparam logic [1:0] SEL_ADDR_B = 2'h2;
    localparam logic [1:0] SEL_OVERLAY = 2'h3;
    // Color phase values of the modulo-three counter.
    localparam logic [1:0] PHASE_RED = 2'h0;
    localparam logic [1:0] PHASE_GREEN = 2'h1;
    localparam logic [1:0] PHASE_BLUE = 2'h2;
    // Widths and reset values.
    localparam int DATA_W = 8;
    localparam int ENTRY_W = 24;
    localparam int ADDR_W = 8;
    localparam int PAL_DEPTH = 256;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [1:0] OVL_FIELD_LSB = 2'h0;
    localparam logic [7:0] BLACK_LEVEL = 8'h00;
endpackage

// File: hw/phap_palette_mem.sv
module phap_palette_mem (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [23:0] wr_data,
    // Read port.
    input wire logic [7:0] rd_addr,
    output logic [23:0] rd_data
);
    logic [23:0] mem [0:phap_pkg::PAL_DEPTH-1];

    // Registered read keeps the data output on a flip-flop.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// File: hw/phap_host_port.sv
// What this block does
// - Host accesses are taken only while unit select is low.
// - Unit select low forces all three video outputs to black.
// - Write when select and write low; byte captured at first rising edge.
// - Read when select and read low; selected byte driven on the bus.
// - Eight-bit two-way bus, bit zero is the least significant bit.
// - Select 00 and 10 address register, 01 palette, 11 overlay colors.
// - Modulo-three phase steps red, green, blue; blue commits and increments.
// - Palette address wraps to zero; overlay ignores upper six address bits.
// - Overlay address low bits 01, 10, 11 pick colors one to three.
module phap_host_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host pins, sampled through two flip-flops.
    input wire logic unit_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] target_select,
    input wire logic [7:0] host_bus_in,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    // Video color input from the pixel path.
    input wire logic [7:0] red_pixel,
    input wire logic [7:0] green_pixel,
    input wire logic [7:0] blue_pixel,
    // Video outputs.
    output logic [7:0] red_video_out,
    output logic [7:0] green_video_out,
    output logic [7:0] blue_video_out
);
    // Two-stage synchronisers for every host pin.
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] pins;
    assign pins = {unit_select_n, read_strobe_n, write_strobe_n, target_select, host_bus_in[6:0]};
    logic bus_msb1;
    logic bus_msb2;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 12'hfff;
            sync2 <= 12'hfff;
            bus_msb1 <= 1'h0;
            bus_msb2 <= 1'h0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            bus_msb1 <= host_bus_in[7];
            bus_msb2 <= bus_msb1;
        end
    end

    wire cs_n = sync2[11];
    wire rd_n = sync2[10];
    wire wr_n = sync2[9];
    wire [1:0] tsel = sync2[8:7];
    wire [7:0] bus_s = {bus_msb2, sync2[6:0]};

    wire wr_active = !cs_n && !wr_n;
    wire rd_active = !cs_n && !rd_n;

    // Previous-cycle state to find the end of each access.
    logic wr_prev;
    logic rd_prev;
    logic [7:0] wr_byte;
    logic [1:0] wr_tsel;
    logic [1:0] rd_tsel;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_prev <= 1'h0;
            rd_prev <= 1'h0;
            wr_byte <= 8'h00;
            wr_tsel <= 2'h0;
            rd_tsel <= 2'h0;
        end else begin
            wr_prev <= wr_active;
            rd_prev <= rd_active;
            if (wr_active) begin
                wr_byte <= bus_s;
                wr_tsel <= tsel;
            end
            if (rd_active) begin
                rd_tsel <= tsel;
            end
        end
    end

    // End of write at first rising strobe.
    wire wr_done = wr_prev && !wr_active;
    wire rd_done = rd_prev && !rd_active;

    wire wr_addr_sel = !wr_tsel[0];
    wire wr_pal_sel = wr_tsel == phap_pkg::SEL_PALETTE;
    wire wr_ovl_sel = wr_tsel == phap_pkg::SEL_OVERLAY;
    wire rd_color_sel = rd_tsel[0];

    // Address register and hidden phase counter.
    logic [7:0] palette_index_reg;
    logic [1:0] color_phase_count;
    logic [7:0] red_hold;
    logic [7:0] green_hold;

    wire color_step = (wr_done && wr_tsel[0]) || (rd_done && rd_color_sel);
    wire blue_step = color_step && color_phase_count == phap_pkg::PHASE_BLUE;

    // Modulo-three phase with commit on blue.
    wire [1:0] next_phase = blue_step ? phap_pkg::PHASE_RED : color_phase_count + 2'h1;
    // Natural eight-bit wrap from last entry to zero.
    wire [7:0] next_index = palette_index_reg + 8'h01;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            palette_index_reg <= phap_pkg::INDEX_RESET;
            color_phase_count <= phap_pkg::PHASE_RED;
            red_hold <= 8'h00;
            green_hold <= 8'h00;
        end else if (wr_done && wr_addr_sel) begin
            palette_index_reg <= wr_byte;
            color_phase_count <= phap_pkg::PHASE_RED;
        end else if (color_step) begin
            color_phase_count <= next_phase;
            if (blue_step) begin
                palette_index_reg <= next_index;
            end
            if (wr_done && color_phase_count == phap_pkg::PHASE_RED) begin
                red_hold <= wr_byte;
            end
            if (wr_done && color_phase_count == phap_pkg::PHASE_GREEN) begin
                green_hold <= wr_byte;
            end
        end
    end

    wire [23:0] entry_wr = {red_hold, green_hold, wr_byte};
    wire commit = wr_done && blue_step;

    // Palette memory.
    logic [23:0] pal_rd;
    phap_palette_mem u_mem (
        .clk(clk),
        .wr_en(commit && wr_pal_sel),
        .wr_addr(palette_index_reg),
        .wr_data(entry_wr),
        .rd_addr(palette_index_reg),
        .rd_data(pal_rd)
    );

    // Overlay colors one to three; code 00 reserved.
    wire [1:0] ovl_idx = palette_index_reg[1:0];
    logic [23:0] overlay [1:3];
    genvar g;
    generate
        for (g = 1; g <= 3; g = g + 1) begin : g_ovl
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    overlay[g] <= 24'h000000;
                end else if (commit && wr_ovl_sel && ovl_idx == 2'(g)) begin
                    overlay[g] <= entry_wr;
                end
            end
        end
    endgenerate

    // Overlay uses only two low bits.
    wire [23:0] ovl_rd = ovl_idx == phap_pkg::OVL_FIELD_LSB ? 24'h000000 :
                         ovl_idx == 2'h1 ? overlay[1] :
                         ovl_idx == 2'h2 ? overlay[2] :
                         overlay[3];
    wire [23:0] color_rd = tsel == phap_pkg::SEL_OVERLAY ? ovl_rd : pal_rd;
    wire [7:0] color_byte = color_phase_count == phap_pkg::PHASE_RED ? color_rd[23:16] :
                            color_phase_count == phap_pkg::PHASE_GREEN ? color_rd[15:8] :
                            color_rd[7:0];
    wire [7:0] rd_byte = tsel[0] ? color_byte : palette_index_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_bus_out <= 8'h00;
            red_video_out <= phap_pkg::BLACK_LEVEL;
            green_video_out <= phap_pkg::BLACK_LEVEL;
            blue_video_out <= phap_pkg::BLACK_LEVEL;
        end else begin
            // Bit zero is the least significant bit.
            host_bus_out <= rd_byte;
            red_video_out <= cs_n ? red_pixel : phap_pkg::BLACK_LEVEL;
            green_video_out <= cs_n ? green_pixel : phap_pkg::BLACK_LEVEL;
            blue_video_out <= cs_n ? blue_pixel : phap_pkg::BLACK_LEVEL;
        end
    end

    assign host_bus_oe = rd_active && rd_prev;

    property p_black;
        @(posedge clk) disable iff (!rst_n)
            !cs_n |=> red_video_out == phap_pkg::BLACK_LEVEL
                && green_video_out == phap_pkg::BLACK_LEVEL
                && blue_video_out == phap_pkg::BLACK_LEVEL;
    endproperty
    a_black: assert property (p_black) else $error("video not black");

    property p_idle_release;
        @(posedge clk) disable iff (!rst_n)
            cs_n && $past(cs_n) |=> !host_bus_oe && $stable(palette_index_reg)
                && $stable(color_phase_count);
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("bus driven unselected");

    property p_oe_read;
        @(posedge clk) disable iff (!rst_n) host_bus_oe |-> !rd_n && !cs_n;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");

    property p_addr_write;
        @(posedge clk) disable iff (!rst_n)
            wr_done && !wr_tsel[0] |=> color_phase_count == phap_pkg::PHASE_RED
                && palette_index_reg == $past(wr_byte);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address write wrong");

    property p_phase_range;
        @(posedge clk) disable iff (!rst_n) color_phase_count != 2'h3;
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("phase out of range");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
            blue_step && !(wr_done && wr_addr_sel) && palette_index_reg == 8'hff
                |=> palette_index_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("index did not wrap");

    sequence s_write_end;
        wr_active ##1 !wr_active;
    endsequence

    property p_write_edge;
        @(posedge clk) disable iff (!rst_n)
            s_write_end |-> wr_done && wr_byte == $past(bus_s);
    endproperty
    a_write_edge: assert property (p_write_edge) else $error("write end missed");

    property p_read_data;
        @(posedge clk) disable iff (!rst_n)
            rd_active && !tsel[0] |=> host_bus_out == $past(palette_index_reg);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");
endmodule

// File: sim/phap_host_model.sv
module phap_host_model (
    // Clock.
    input wire logic clk,
    // Host control pins.
    output logic unit_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [1:0] target_select,
    // Data the host drives, and the resolved bus wire.
    output logic [7:0] drv_data,
    output logic drv_en,
    input wire logic [7:0] bus,
    output logic [7:0] rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        unit_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        target_select = 2'h0;
        drv_data = 8'h00;
        drv_en = 1'b0;
        rd_byte = 8'h00;
    end

    // One strobed access; pins change at the falling edge and stand for eight cycles.
    task automatic xfer(input logic rd, input logic [1:0] ts, input logic [7:0] d, input logic sel);
        @(negedge clk);
        target_select = ts;
        drv_data = d;
        drv_en = !rd;
        unit_select_n = !sel;
        read_strobe_n = !rd;
        write_strobe_n = rd;
        repeat (8) @(negedge clk);
        rd_byte = bus;
        unit_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        repeat (2) @(negedge clk);
        drv_en = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// File: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, host_bus_oe, drv_en;
    logic [1:0] target_select;
    logic unit_select_n, read_strobe_n, write_strobe_n;
    logic [7:0] host_bus_out, drv_data, rd_byte, r_pix, g_pix, b_pix, r_out, g_out, b_out;
    logic [7:0] base, nxt;
    logic [7:0] ent [9];
    wire [7:0] bus = host_bus_oe ? host_bus_out : (drv_en ? drv_data : ~drv_data);
    int errors = 0, n_tests = 0, seed = 78676, low_cnt = 0, high_cnt = 0;

    phap_host_port dut (.clk(clk), .rst_n(rst_n), .unit_select_n(unit_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .target_select(target_select), .host_bus_in(bus), .host_bus_out(host_bus_out),
        .host_bus_oe(host_bus_oe), .red_pixel(r_pix), .green_pixel(g_pix),
        .blue_pixel(b_pix), .red_video_out(r_out), .green_video_out(g_out),
        .blue_video_out(b_out));
    phap_host_model host (.clk(clk), .unit_select_n(unit_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .target_select(target_select), .drv_data(drv_data), .drv_en(drv_en), .bus(bus),
        .rd_byte(rd_byte));

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Index after a number of whole red, green, blue entries, wrapping at the top.
    function automatic logic [7:0] exp_index(input logic [7:0] start, input int entries);
        return start + 8'(entries);
    endfunction

    task automatic go(input logic rd, input logic [1:0] ts, input logic [7:0] d, input logic s);
        host.xfer(rd, ts, d, s);
        chk({23'h0, host_bus_oe}, 24'h0);
    endtask

    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Random pixels each cycle; video is black while selected and follows the pixels otherwise.
    always @(negedge clk) begin
        low_cnt = unit_select_n ? 0 : low_cnt + 1;
        high_cnt = unit_select_n ? high_cnt + 1 : 0;
        if (low_cnt == 5) chk({r_out, g_out, b_out}, 24'h0);
        if (high_cnt == 5 && rst_n) chk({r_out, g_out, b_out}, {r_pix, g_pix, b_pix});
        {r_pix, g_pix, b_pix} = 24'($random(seed));
    end

    initial begin
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk({23'h0, host_bus_oe}, 24'h0);
        for (int k = 0; k < 2; k++) begin
            base = k ? 8'($random(seed)) : 8'hfe;
            nxt = exp_index(base, 2);
            go(1'b0, phap_pkg::SEL_ADDR_A, base, 1'b1);
            for (int i = 0; i < 6; i++) begin
                ent[i] = 8'($random(seed));
                go(1'b0, phap_pkg::SEL_PALETTE, ent[i], 1'b1);
            end
            go(1'b1, phap_pkg::SEL_ADDR_B, 8'h5a, 1'b1);
            chk(rd_byte, nxt);
            go(1'b0, phap_pkg::SEL_ADDR_A, base, 1'b1);
            for (int i = 0; i < 6; i++) begin
                go(1'b1, phap_pkg::SEL_PALETTE, 8'h5a, 1'b1);
                chk(rd_byte, ent[i]);
                if (i == 0) begin
                    go(1'b1, phap_pkg::SEL_ADDR_B, 8'h5a, 1'b1);
                    chk(rd_byte, base);
                end
            end
            $display("palette pass %0d done", k);
        end
        go(1'b0, phap_pkg::SEL_ADDR_A, 8'hfd, 1'b1);
        for (int i = 0; i < 9; i++) begin
            ent[i] = 8'($random(seed));
            go(1'b0, phap_pkg::SEL_OVERLAY, ent[i], 1'b1);
        end
        go(1'b0, phap_pkg::SEL_ADDR_A, 8'h01, 1'b1);
        for (int i = 0; i < 12; i++) begin
            go(1'b1, phap_pkg::SEL_OVERLAY, 8'h5a, 1'b1);
            chk(rd_byte, i < 9 ? ent[i] : 8'h00);
        end
        $display("overlay done");
        go(1'b0, phap_pkg::SEL_ADDR_A, 8'h10, 1'b0);
        go(1'b0, phap_pkg::SEL_PALETTE, 8'h33, 1'b0);
        go(1'b1, phap_pkg::SEL_ADDR_B, 8'h3c, 1'b0);
        chk(rd_byte, 8'hc3);
        go(1'b1, phap_pkg::SEL_ADDR_B, 8'h5a, 1'b1);
        chk(rd_byte, exp_index(8'h01, 4));
        $display("deselected access done");
        report_and_stop();
    end

    initial begin
        #400us;
        errors++;
        report_and_stop();
    end
endmodule
